/* File: logic/iprc_pkg.sv */
// Package: register map, field layout and reset values of the priority slice
package iprc_pkg;
    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] IPRC_OFF_CMP4   = 12'h000;
    localparam logic [11:0] IPRC_OFF_ADCP   = 12'h004;
    localparam logic [11:0] IPRC_OFF_LEVELS = 12'h008;
    localparam logic [11:0] IPRC_OFF_ACTIVE = 12'h00C;
    localparam logic [11:0] IPRC_OFF_PEND   = 12'h010;

    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int IPRC_PRIO_W       = 3;
    localparam int IPRC_NSRC         = 4;
    localparam int IPRC_CMP4_LSB     = 0;
    localparam int IPRC_ADCP0_LSB    = 4;
    localparam int IPRC_ADCP1_LSB    = 8;
    localparam int IPRC_ADCP2_LSB    = 12;
    localparam int IPRC_SRC_CMP4     = 0;
    localparam int IPRC_SRC_ADCP0    = 1;
    localparam int IPRC_SRC_ADCP1    = 2;
    localparam int IPRC_SRC_ADCP2    = 3;

    // ------------------------------------------------------------------
    // Reset and level codes
    // ------------------------------------------------------------------
    localparam logic [2:0]  IPRC_PRIO_RESET   = 3'h4;
    localparam logic [2:0]  IPRC_PRIO_OFF     = 3'h0;
    localparam logic [2:0]  IPRC_PRIO_LOWEST  = 3'h1;
    localparam logic [2:0]  IPRC_PRIO_HIGHEST = 3'h7;
    localparam logic [15:0] IPRC_CMP4_MASK    = 16'h0007;
    localparam logic [15:0] IPRC_ADCP_MASK    = 16'h7770;
endpackage

/* File: logic/iprc_field.sv */
// One three-bit priority field with its request gate
`timescale 1ns/10ps
module iprc_field
    import iprc_pkg::*;
(
    // Clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // Software write
    input  wire logic                   wr_en,
    input  wire logic [IPRC_PRIO_W-1:0] wr_data,
    // Source event
    input  wire logic                   src_req,
    // Results
    output logic      [IPRC_PRIO_W-1:0] level,
    output logic                        req_out
);
    logic [IPRC_PRIO_W-1:0] level_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_reg <= IPRC_PRIO_RESET;
        end else if (wr_en) begin
            level_reg <= wr_data;
        end
    end

    // Level equals field code; code zero blocks the source
    assign level   = level_reg;
    assign req_out = src_req && (level_reg != IPRC_PRIO_OFF);
endmodule // iprc_field

/* File: logic/iprc_regs.sv */
// Interrupt priority slice: comparator four and ADC pairs zero to two
//
// Contract
// - Bits 2-0 of the first register hold the writable priority of the comparator four source.
// - Field code 111 gives level seven, the highest, and every other code gives its own numeric level.
// - Field code 001 gives level one, the lowest level that still raises a request.
// - Field code 000 disables the source so it never requests service.
// - Bits 15-3 of the first register ignore writes and read as zero.
`timescale 1ns/10ps
module iprc_regs
    import iprc_pkg::*;
(
    // APB slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Source events, bit order: cmp4, pair0, pair1, pair2
    input  wire logic [3:0]  src_req,
    // Gated requests and levels
    output logic      [3:0]  irq_req,
    output logic      [2:0]  comparator_four_priority,
    output logic      [2:0]  adc_pair_zero_priority,
    output logic      [2:0]  adc_pair_one_priority,
    output logic      [2:0]  adc_pair_two_priority,
    output logic      [2:0]  top_level
);
    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic        wr_acc;
    logic        hit;
    logic        wr_cmp4;
    logic        wr_adcp;
    logic        wr_lane0;
    logic        wr_lane1;
    logic [31:0] rd_next;
    logic [31:0] prdata_reg;
    logic [2:0]  lvl [IPRC_NSRC];
    logic [3:0]  req_w;
    logic [3:0]  pend_reg;
    logic [2:0]  top_next;
    logic [2:0]  top_reg;

    assign wr_acc   = psel && penable && pwrite;
    assign wr_lane0 = pstrb[0];
    assign wr_lane1 = pstrb[1];
    assign wr_cmp4  = wr_acc && (paddr == IPRC_OFF_CMP4) && wr_lane0;
    assign wr_adcp  = wr_acc && (paddr == IPRC_OFF_ADCP);
    assign hit      = (paddr == IPRC_OFF_CMP4) || (paddr == IPRC_OFF_ADCP) || (paddr == IPRC_OFF_LEVELS)
                   || (paddr == IPRC_OFF_ACTIVE) || (paddr == IPRC_OFF_PEND);
    // Zero wait states; unmapped or writes to read-only registers flag an error
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && (!hit || (pwrite && paddr != IPRC_OFF_CMP4 && paddr != IPRC_OFF_ADCP));

    // ------------------------------------------------------------------
    // Priority fields
    // ------------------------------------------------------------------
    iprc_field u_cmp4 (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr_cmp4),
        .wr_data (pwdata[IPRC_CMP4_LSB +: IPRC_PRIO_W]),
        .src_req (src_req[IPRC_SRC_CMP4]),
        .level   (lvl[IPRC_SRC_CMP4]),
        .req_out (req_w[IPRC_SRC_CMP4])
    );
    iprc_field u_adcp0 (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr_adcp && wr_lane0),
        .wr_data (pwdata[IPRC_ADCP0_LSB +: IPRC_PRIO_W]),
        .src_req (src_req[IPRC_SRC_ADCP0]),
        .level   (lvl[IPRC_SRC_ADCP0]),
        .req_out (req_w[IPRC_SRC_ADCP0])
    );
    iprc_field u_adcp1 (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr_adcp && wr_lane1),
        .wr_data (pwdata[IPRC_ADCP1_LSB +: IPRC_PRIO_W]),
        .src_req (src_req[IPRC_SRC_ADCP1]),
        .level   (lvl[IPRC_SRC_ADCP1]),
        .req_out (req_w[IPRC_SRC_ADCP1])
    );
    iprc_field u_adcp2 (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (wr_adcp && wr_lane1),
        .wr_data (pwdata[IPRC_ADCP2_LSB +: IPRC_PRIO_W]),
        .src_req (src_req[IPRC_SRC_ADCP2]),
        .level   (lvl[IPRC_SRC_ADCP2]),
        .req_out (req_w[IPRC_SRC_ADCP2])
    );

    assign comparator_four_priority = lvl[IPRC_SRC_CMP4];
    assign adc_pair_zero_priority   = lvl[IPRC_SRC_ADCP0];
    assign adc_pair_one_priority    = lvl[IPRC_SRC_ADCP1];
    assign adc_pair_two_priority    = lvl[IPRC_SRC_ADCP2];

    // ------------------------------------------------------------------
    // Gated requests and highest active level
    // ------------------------------------------------------------------
    // Registered so the request never glitches on a field write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_reg <= 4'h0;
        end else begin
            pend_reg <= req_w;
        end
    end

    always_comb begin
        top_next = IPRC_PRIO_OFF;
        for (int i = 0; i < IPRC_NSRC; i++) begin
            if (req_w[i] && (lvl[i] > top_next)) begin
                top_next = lvl[i];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            top_reg <= IPRC_PRIO_OFF;
        end else begin
            top_reg <= top_next;
        end
    end

    assign irq_req   = pend_reg;
    assign top_level = top_reg;

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    always_comb begin
        rd_next = 32'h0000_0000;
        unique case (paddr)
            IPRC_OFF_CMP4: begin
                rd_next[IPRC_CMP4_LSB +: IPRC_PRIO_W] = lvl[IPRC_SRC_CMP4];
            end
            IPRC_OFF_ADCP: begin
                rd_next[IPRC_ADCP0_LSB +: IPRC_PRIO_W] = lvl[IPRC_SRC_ADCP0];
                rd_next[IPRC_ADCP1_LSB +: IPRC_PRIO_W] = lvl[IPRC_SRC_ADCP1];
                rd_next[IPRC_ADCP2_LSB +: IPRC_PRIO_W] = lvl[IPRC_SRC_ADCP2];
            end
            IPRC_OFF_LEVELS: begin
                rd_next[2:0] = top_reg;
            end
            IPRC_OFF_ACTIVE: begin
                rd_next[3:0] = pend_reg;
            end
            IPRC_OFF_PEND: begin
                rd_next[3:0] = src_req;
            end
            default: begin
                rd_next = 32'h0000_0000;
            end
        endcase
    end

    // Data captured in setup so it is ready at the access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_reg <= rd_next;
        end
    end

    assign prdata = prdata_reg;
endmodule // iprc_regs

/* File: test/iprc_regs_sva.sv */
// Checker: properties of the priority slice at its ports
`timescale 1ns/10ps
module iprc_regs_chk
    import iprc_pkg::*;
(
    input wire logic        pclk, presetn, psel, penable, pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic [3:0]  pstrb, src_req, irq_req,
    input wire logic [2:0]  comparator_four_priority, adc_pair_zero_priority,
    input wire logic [2:0]  adc_pair_one_priority, adc_pair_two_priority, top_level
);
    // -----------------------------------------------------------------
    // Properties
    // -----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire rd_acc = psel && penable && !pwrite;
    cmp_write_a: assert property (psel && penable && pwrite && paddr == 12'h000 && pstrb[0]
        |=> comparator_four_priority == $past(pwdata[2:0])) else $error("field write lost");
    top_seven_a: assert property (src_req[3] && adc_pair_two_priority == 3'h7
        |=> top_level == 3'h7) else $error("level seven not on top");
    low_one_a: assert property (src_req == 4'h1 && comparator_four_priority == 3'h1
        |=> irq_req == 4'h1 && top_level == 3'h1) else $error("level one not raised");
    off_gate_a: assert property (comparator_four_priority == 3'h0 |=> !irq_req[0])
        else $error("disabled source requested");
    upper_zero_a: assert property (rd_acc && paddr == 12'h000 |-> prdata[31:3] == 29'h0)
        else $error("unused bits read nonzero");
    pair_map_a: assert property (rd_acc && paddr == 12'h004 |-> prdata == {17'h0, adc_pair_two_priority,
        1'b0, adc_pair_one_priority, 1'b0, adc_pair_zero_priority, 4'h0}) else $error("pair layout wrong");
    reset_val_a: assert property ($rose(presetn) |-> comparator_four_priority == 3'h4
        && adc_pair_one_priority == 3'h4) else $error("reset level wrong");
endmodule // iprc_regs_chk

bind iprc_regs iprc_regs_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pstrb(pstrb), .src_req(src_req),
    .irq_req(irq_req), .comparator_four_priority(comparator_four_priority),
    .adc_pair_zero_priority(adc_pair_zero_priority), .adc_pair_one_priority(adc_pair_one_priority),
    .adc_pair_two_priority(adc_pair_two_priority), .top_level(top_level));

/* File: test/iprc_regs_tb.sv */
// Testbench: APB access, field layout and request gating of the priority slice
`timescale 1ns/10ps
module iprc_regs_tb;
    import iprc_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0]  pstrb = 4'hF, src_req = 4'h0, irq_req;
    logic [2:0]  cmp4_lvl, p0_lvl, p1_lvl, p2_lvl, top_level;
    logic        err;
    int          miscompares = 0, checked = 0;
    always #10 pclk = ~pclk;
    iprc_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .src_req(src_req), .irq_req(irq_req), .comparator_four_priority(cmp4_lvl),
        .adc_pair_zero_priority(p0_lvl), .adc_pair_one_priority(p1_lvl), .adc_pair_two_priority(p2_lvl),
        .top_level(top_level));
    // -----------------------------------------------------------------
    // Shared tasks
    // -----------------------------------------------------------------
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Holds the request until pready is seen high, then releases
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 16) begin
            miscompares++;
            tally_and_finish();
        end
        rd = prdata; err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    // -----------------------------------------------------------------
    // Scenarios
    // -----------------------------------------------------------------
    task automatic reset_values();
        apb(1'b0, 12'h000, 32'h0); chk(rd, 32'h0000_0004);
        apb(1'b0, 12'h004, 32'h0); chk(rd, 32'h0000_4440);
    endtask
    task automatic field_layout();
        apb(1'b1, 12'h000, 32'hFFFF_FFFF); apb(1'b0, 12'h000, 32'h0); chk(rd, 32'h0000_0007);
        apb(1'b1, 12'h004, 32'hFFFF_FFFF); apb(1'b0, 12'h004, 32'h0); chk(rd, 32'h0000_7770);
        apb(1'b1, 12'h004, 32'h0000_5320);
        // The write lands at the access edge, so look one edge later
        @(posedge pclk);
        chk({29'h0, p0_lvl}, 32'h2);
        chk({29'h0, p1_lvl}, 32'h3);
        chk({29'h0, p2_lvl}, 32'h5);
        apb(1'b1, 12'h008, 32'h7); chk({31'h0, err}, 32'h1);
        pstrb <= 4'h0;
        apb(1'b1, 12'h000, 32'h1);
        @(posedge pclk);
        chk({29'h0, cmp4_lvl}, 32'h7);
        pstrb <= 4'hF;
    endtask
    // Every code on the comparator source with only that source asserted
    task automatic code_sweep();
        src_req <= 4'h1;
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, 12'h000, 32'(c));
            @(posedge pclk);
            @(posedge pclk);
            chk({29'h0, cmp4_lvl}, 32'(c));
            chk({28'h0, irq_req}, (c == 0) ? 32'h0 : 32'h1);
            chk({29'h0, top_level}, 32'(c));
        end
        src_req <= 4'hF;
        @(posedge pclk);
        @(posedge pclk);
        chk({28'h0, irq_req}, 32'hF); chk({29'h0, top_level}, 32'h7);
        // Only pair two left enabled, at the top level
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b1, 12'h004, 32'h0000_7000);
        @(posedge pclk);
        @(posedge pclk);
        chk({28'h0, irq_req}, 32'h8);
        chk({29'h0, top_level}, 32'h7);
    endtask
    // Reset in mid-run must bring every field back to level four
    task automatic reset_again();
        src_req <= 4'h0;
        presetn <= 1'b0;
        @(posedge pclk);
        chk({29'h0, cmp4_lvl}, 32'h4);
        chk({29'h0, p2_lvl}, 32'h4);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        reset_values();
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        reset_values();
        field_layout();
        code_sweep();
        reset_again();
        tally_and_finish();
    end
endmodule // iprc_regs_tb
